// file: mre_map.vh
//
// Contract
// RULE1 - Register move copies file register to accumulator (d=0) or back to itself (d=1).
// RULE2 - Register move sets zero flag from the moved value; self move tests zero.
// RULE3 - Accumulator store writes accumulator to file register 0..127; flags unchanged.
// RULE4 - Load literal puts 8-bit operand into accumulator; flags unchanged.
// RULE5 - Interrupt return pops stack into program counter and sets interrupt enable.
// RULE6 - Literal return loads 8-bit operand into accumulator; flags unchanged.
// RULE7 - Literal return pops top of stack into program counter.
// RULE8 - Literal return takes two instruction cycles; second refills the fetch.
// RULE9 - Left rotate through carry goes to accumulator (d=0) or register (d=1).
// RULE10 - Rotate moves bit 7 into carry, old carry into bit 0; nothing else.
// RULE11 - No operation takes one cycle and only advances the program counter.
`ifndef MRE_MAP_VH
`define MRE_MAP_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define MRE_OFF_INSTR   12'h000
`define MRE_OFF_ACC     12'h004
`define MRE_OFF_FLAGS   12'h008
`define MRE_OFF_PC      12'h00C
`define MRE_OFF_STATE   12'h010
`define MRE_OFF_STACK   12'h014
`define MRE_FILE_BIT    9

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define MRE_FLD_OP_HI   11
`define MRE_FLD_OP_LO   9
`define MRE_FLD_DEST    8
`define MRE_FLG_CARRY   0
`define MRE_FLG_ZERO    2
`define MRE_FLG_GIE     7
`define MRE_ST_BUSY     0
`define MRE_ST_ILLEGAL  1

// ----------------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------------
`define MRE_OP_NOP      3'h0
`define MRE_OP_MOVE     3'h1
`define MRE_OP_STORE    3'h2
`define MRE_OP_LOADK    3'h3
`define MRE_OP_RETI     3'h4
`define MRE_OP_RETK     3'h5
`define MRE_OP_ROTL     3'h6

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define MRE_RST_ACC     8'h00
`define MRE_RST_PC      13'h0000
`define MRE_RST_INSTR   12'h000
`define MRE_CYC_DIV     4

`endif

// file: mre_stack.v
`timescale 1ns/100ps
module mre_stack #(
    parameter DEPTH = 8,
    parameter AW    = 3,
    parameter DW    = 13
) (
    input  wire          clk_i,
    input  wire          rst_b_i,
    input  wire          push_i,
    input  wire          pop_i,
    input  wire [DW-1:0] push_data_i,
    output wire [DW-1:0] top_o,
    output reg  [AW:0]   depth_o
);
    localparam [AW:0] FULL = DEPTH;

    reg [DW-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] ptr_r;
    wire [AW-1:0] top_idx = ptr_r - 1'b1;

    assign top_o = mem[top_idx];

    // ------------------------------------------------------------------
    // Circular stack: overflow overwrites, underflow wraps.
    // ------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            ptr_r   <= {AW{1'b0}};
            depth_o <= {(AW+1){1'b0}};
        end else if (push_i && pop_i) begin
            mem[top_idx] <= push_data_i;
        end else if (push_i) begin
            mem[ptr_r] <= push_data_i;
            ptr_r      <= ptr_r + 1'b1;
            if (depth_o != FULL)
                depth_o <= depth_o + 1'b1;
        end else if (pop_i) begin
            ptr_r <= top_idx;
            if (depth_o != {(AW+1){1'b0}})
                depth_o <= depth_o - 1'b1;
        end
    end
endmodule

// file: mre_core.v
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "mre_map.vh"
module mre_core #(
    parameter CYC_DIV     = `MRE_CYC_DIV,
    parameter STACK_DEPTH = 8
) (
    input  wire        clk_i,
    input  wire        rst_b_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    output reg         busy_o,
    output reg         gie_o
);
    localparam ST_IDLE  = 2'd0;
    localparam ST_EXEC  = 2'd1;
    localparam ST_FLUSH = 2'd2;

    reg  [7:0]  file_mem [0:127];
    reg  [11:0] instr_r;
    reg  [7:0]  acc_r;
    reg  [12:0] pc_r;
    reg         carry_r;
    reg         zero_r;
    reg         illegal_r;
    reg  [1:0]  state_r;
    reg  [7:0]  div_r;
    reg         tick_r;
    wire [12:0] top_of_stack;
    wire [3:0]  depth;

    // ------------------------------------------------------------------
    // Instruction fields.
    // ------------------------------------------------------------------
    wire [2:0] op    = instr_r[`MRE_FLD_OP_HI:`MRE_FLD_OP_LO];
    wire       dest  = instr_r[`MRE_FLD_DEST];
    wire [6:0] faddr = instr_r[6:0];
    wire [7:0] lit   = instr_r[7:0];
    wire [7:0] fval  = file_mem[faddr];
    wire [7:0] rot   = {fval[6:0], carry_r};

    // ------------------------------------------------------------------
    // APB decode.
    // ------------------------------------------------------------------
    wire acc_ph  = psel_i && penable_i;
    wire commit  = acc_ph && pready_o;
    wire is_file = paddr_i[`MRE_FILE_BIT];
    wire [6:0] pidx = paddr_i[8:2];

    function mapped;
        input [11:0] a;
        begin
            mapped = a[`MRE_FILE_BIT] || a == `MRE_OFF_INSTR ||
                     a == `MRE_OFF_ACC || a == `MRE_OFF_FLAGS ||
                     a == `MRE_OFF_PC || a == `MRE_OFF_STATE ||
                     a == `MRE_OFF_STACK;
        end
    endfunction

    wire bad   = !mapped(paddr_i) || paddr_i[1:0] != 2'b00 ||
                 (pwrite_i && paddr_i == `MRE_OFF_INSTR && busy_o);
    wire wr_ok = commit && pwrite_i && !bad;
    wire wr_in = wr_ok && paddr_i == `MRE_OFF_INSTR;

    wire in_exec = tick_r && state_r == ST_EXEC;
    wire pop     = in_exec && (op == `MRE_OP_RETI || op == `MRE_OP_RETK);
    wire push    = wr_ok && paddr_i == `MRE_OFF_STACK;

    mre_stack #(
        .DEPTH       (STACK_DEPTH),
        .AW          (3),
        .DW          (13)
    ) u_stack (
        .clk_i       (clk_i),
        .rst_b_i     (rst_b_i),
        .push_i      (push),
        .pop_i       (pop),
        .push_data_i (pwdata_i[12:0]),
        .top_o       (top_of_stack),
        .depth_o     (depth)
    );

    // ------------------------------------------------------------------
    // Instruction cycle enable.
    // ------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            div_r  <= 8'h00;
            tick_r <= 1'b0;
        end else if (div_r == CYC_DIV - 1) begin
            div_r  <= 8'h00;
            tick_r <= 1'b1;
        end else begin
            div_r  <= div_r + 8'h01;
            tick_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // APB slave answer.
    // ------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            prdata_o  <= 32'h0000_0000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else if (acc_ph && !pready_o) begin
            pready_o  <= 1'b1;
            pslverr_o <= bad;
            prdata_o  <= 32'h0000_0000;
            if (!pwrite_i && !bad) begin
                if (is_file)
                    prdata_o <= {24'h000000, file_mem[pidx]};
                else case (paddr_i)
                    `MRE_OFF_INSTR: prdata_o <= {20'h00000, instr_r};
                    `MRE_OFF_ACC:   prdata_o <= {24'h000000, acc_r};
                    `MRE_OFF_FLAGS: prdata_o <= {24'h000000, gie_o,
                                                 4'h0, zero_r, 1'b0,
                                                 carry_r};
                    `MRE_OFF_PC:    prdata_o <= {19'h0, pc_r};
                    `MRE_OFF_STATE: prdata_o <= {30'h0,
                                                 illegal_r, busy_o};
                    `MRE_OFF_STACK: prdata_o <= {12'h000, depth,
                                                 3'h0, top_of_stack};
                    default:        prdata_o <= 32'h0000_0000;
                endcase
            end
        end else begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer and architectural state. Execution wins over software.
    // ------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            state_r   <= ST_IDLE;
            busy_o    <= 1'b0;
            instr_r   <= `MRE_RST_INSTR;
            acc_r     <= `MRE_RST_ACC;
            pc_r      <= `MRE_RST_PC;
            carry_r   <= 1'b0;
            zero_r    <= 1'b0;
            gie_o     <= 1'b0;
            illegal_r <= 1'b0;
        end else begin
            if (wr_ok && is_file)
                file_mem[pidx] <= pwdata_i[7:0];
            if (wr_ok && paddr_i == `MRE_OFF_ACC)
                acc_r <= pwdata_i[7:0];
            if (wr_ok && paddr_i == `MRE_OFF_PC)
                pc_r <= pwdata_i[12:0];
            if (wr_ok && paddr_i == `MRE_OFF_FLAGS) begin
                carry_r <= pwdata_i[`MRE_FLG_CARRY];
                zero_r  <= pwdata_i[`MRE_FLG_ZERO];
                gie_o   <= pwdata_i[`MRE_FLG_GIE];
            end
            case (state_r)
                ST_IDLE: begin
                    if (wr_in) begin
                        instr_r   <= pwdata_i[11:0];
                        illegal_r <= 1'b0;
                        busy_o    <= 1'b1;
                        state_r   <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    if (tick_r) begin
                        pc_r    <= pc_r + 13'h0001; // see RULE11
                        state_r <= ST_IDLE;
                        busy_o  <= 1'b0;
                        case (op)
                            `MRE_OP_NOP: begin
                                state_r <= ST_IDLE; // see RULE11
                            end
                            `MRE_OP_MOVE: begin
                                if (dest)
                                    file_mem[faddr] <= fval; // see RULE1
                                else
                                    acc_r <= fval; // see RULE1
                                zero_r <= (fval == 8'h00); // see RULE2
                            end
                            `MRE_OP_STORE: begin
                                file_mem[faddr] <= acc_r; // see RULE3
                            end
                            `MRE_OP_LOADK: begin
                                acc_r <= lit; // see RULE4
                            end
                            `MRE_OP_RETI: begin
                                pc_r    <= top_of_stack; // see RULE5
                                gie_o   <= 1'b1; // see RULE5
                                state_r <= ST_FLUSH;
                                busy_o  <= 1'b1;
                            end
                            `MRE_OP_RETK: begin
                                acc_r   <= lit; // see RULE6
                                pc_r    <= top_of_stack; // see RULE7
                                state_r <= ST_FLUSH; // see RULE8
                                busy_o  <= 1'b1;
                            end
                            `MRE_OP_ROTL: begin
                                if (dest)
                                    file_mem[faddr] <= rot; // see RULE9
                                else
                                    acc_r <= rot; // see RULE9
                                carry_r <= fval[7]; // see RULE10
                            end
                            default: begin
                                illegal_r <= 1'b1;
                            end
                        endcase
                    end
                end
                ST_FLUSH: begin
                    if (tick_r) begin
                        state_r <= ST_IDLE; // see RULE8
                        busy_o  <= 1'b0;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    busy_o  <= 1'b0;
                end
            endcase
        end
    end
endmodule

// file: mre_checker.sv
`timescale 1ns/100ps
module mre_checker #(
    parameter CYC_DIV     = 4,
    parameter STACK_DEPTH = 8
) (
    input wire logic        clk_i,
    input wire logic        rst_b_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        busy_o,
    input wire logic        gie_o
);
    // ------------------------------------------------------------
    // Bus and execution checks
    // ------------------------------------------------------------
    localparam int MAXB = 2 * CYC_DIV + 2;
    wire wr_done  = psel_i & penable_i & pready_o & pwrite_i;
    wire instr_wr = wr_done & !pslverr_o & (paddr_i == 12'h000);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    a_ready_one_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready held longer than one cycle");
    a_ready_in_access: assert property (pready_o |-> psel_i && penable_i)
        else $error("ready outside an access phase");
    a_ready_latency: assert property
        (psel_i && penable_i && !$past(penable_i) |=> pready_o)
        else $error("ready not one cycle after access start");
    a_err_with_ready: assert property (pslverr_o |-> pready_o)
        else $error("error flag without ready");
    a_misalign_err: assert property (pready_o && paddr_i[1:0] != 2'b00
        |-> pslverr_o) else $error("misaligned access not refused");
    a_err_read_zero: assert property (pready_o && pslverr_o && !pwrite_i
        |-> prdata_o == 32'h0) else $error("refused read not zero");
    a_busy_start: assert property ($rose(busy_o) |-> $past(instr_wr))
        else $error("busy rose without an instruction write");
    a_busy_bounded: assert property ($rose(busy_o) |-> ##[1:MAXB] !busy_o)
        else $error("instruction did not complete in time");
    a_gie_set_cause: assert property ($rose(gie_o) |-> $past(busy_o) || $past(wr_done))
        else $error("interrupt enable rose without a cause");
    a_instr_busy_err: assert property
        (wr_done && paddr_i == 12'h000 && busy_o |-> pslverr_o)
        else $error("instruction write while busy not refused");
    c_instr_run: cover property (instr_wr ##1 busy_o ##[1:MAXB] !busy_o);
    c_refused: cover property (pready_o && pslverr_o);
    c_gie_set: cover property ($rose(gie_o));
endmodule

bind mre_core mre_checker #(.CYC_DIV(CYC_DIV), .STACK_DEPTH(STACK_DEPTH))
    i_chk (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .busy_o(busy_o), .gie_o(gie_o));

// file: move_return_rotate_exec_tb_top.sv
`timescale 1ns/100ps
`include "mre_map.vh"
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin \
    miscompares++; $display("CHECK FAILED %s expected %h seen %h", \
    nm, e, s); end end
module move_return_rotate_exec_tb_top;
    typedef struct {logic [11:0] ins; logic [6:0] f;
        logic [7:0] fin, fl, acc, fv, efl; logic [12:0] pc;} mre_row_t;
    logic        clk_i     = 1'b0;
    logic        rst_b_i   = 1'b0;
    logic        psel_i    = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i  = 1'b0;
    logic [11:0] paddr_i   = 12'h000;
    logic [31:0] pwdata_i  = 32'h0;
    logic [31:0] rd;
    logic        er;
    wire  [31:0] prdata_o;
    wire         pready_o, pslverr_o, busy_o, gie_o;
    int          compares    = 0;
    int          miscompares = 0;
    mre_row_t    rows[9];
    mre_core #(.CYC_DIV(1), .STACK_DEPTH(8)) i_dut (.clk_i(clk_i),
        .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .busy_o(busy_o), .gie_o(gie_o));
    initial forever #4 clk_i = ~clk_i;
    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task tally_and_finish;
        if (miscompares == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= w;
        paddr_i <= a; pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        k = 0;
        do begin @(posedge clk_i); k++; end
        while (pready_o !== 1'b1 && k < 20);
        if (pready_o !== 1'b1) begin
            miscompares++;
            tally_and_finish();
        end else begin
            rd = prdata_o;
            er = pslverr_o;
            psel_i <= 1'b0;
            penable_i <= 1'b0;
        end
    endtask
    task run(input mre_row_t r);
        int k, j;
        logic [11:0] fa;
        fa = 12'h200 + {3'h0, r.f, 2'b00};
        apb(1'b1, `MRE_OFF_ACC, 32'h5A); apb(1'b1, `MRE_OFF_FLAGS, r.fl);
        apb(1'b1, fa, r.fin); apb(1'b1, `MRE_OFF_PC, 32'h10);
        apb(1'b1, `MRE_OFF_STACK, 32'h123); apb(1'b1, `MRE_OFF_INSTR, r.ins);
        k = 0;
        for (j = 0; j < 30; j++) begin
            @(posedge clk_i);
            if (busy_o === 1'b1) k++;
            else if (k > 0 || j > 2) break;
        end
        `CHK("busy cycles", (r.ins[11:10] == 2'b10) ? 2 : 1, k)
        apb(1'b0, `MRE_OFF_ACC, 0); `CHK("acc", {24'h0, r.acc}, rd)
        apb(1'b0, `MRE_OFF_FLAGS, 0); `CHK("flags", {24'h0, r.efl}, rd)
        apb(1'b0, fa, 0); `CHK("file", {24'h0, r.fv}, rd)
        apb(1'b0, `MRE_OFF_PC, 0); `CHK("pc", {19'h0, r.pc}, rd)
        `CHK("gie", r.efl[7], gie_o)
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rows = '{'{12'h205, 7'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 13'h11},
            '{12'h37F, 7'h7F, 8'h80, 8'h04, 8'h5A, 8'h80, 8'h00, 13'h11},
            '{12'h400, 7'h00, 8'h11, 8'h05, 8'h5A, 8'h5A, 8'h05, 13'h11},
            '{12'h6FF, 7'h01, 8'h22, 8'h05, 8'hFF, 8'h22, 8'h05, 13'h11},
            '{12'h800, 7'h01, 8'h22, 8'h00, 8'h5A, 8'h22, 8'h80, 13'h123},
            '{12'hA00, 7'h01, 8'h22, 8'h85, 8'h00, 8'h22, 8'h85, 13'h123},
            '{12'hC09, 7'h09, 8'hA5, 8'h00, 8'h4A, 8'hA5, 8'h01, 13'h11},
            '{12'hD09, 7'h09, 8'h3C, 8'h05, 8'h5A, 8'h79, 8'h04, 13'h11},
            '{12'h000, 7'h01, 8'h22, 8'h85, 8'h5A, 8'h22, 8'h85, 13'h11}};
        repeat (20) @(posedge clk_i);
        rst_b_i <= 1'b1;
        foreach (rows[i]) run(rows[i]);
        rst_b_i <= 1'b0;
        repeat (20) @(posedge clk_i);
        rst_b_i <= 1'b1;
        apb(1'b0, `MRE_OFF_ACC, 0); `CHK("reset acc", 32'h0, rd)
        apb(1'b0, `MRE_OFF_PC, 0); `CHK("reset pc", 32'h0, rd)
        apb(1'b0, `MRE_OFF_FLAGS, 0); `CHK("reset flags", 32'h0, rd)
        `CHK("reset gie", 1'b0, gie_o)
        apb(1'b0, 12'h018, 0); `CHK("unmapped err", 1'b1, er)
        `CHK("unmapped data", 32'h0, rd)
        apb(1'b1, 12'h006, 32'hFF); `CHK("misaligned err", 1'b1, er)
        apb(1'b0, `MRE_OFF_STACK, 0); `CHK("reset depth", 4'h0, rd[19:16])
        apb(1'b1, `MRE_OFF_INSTR, 32'hE00);
        repeat (4) @(posedge clk_i);
        apb(1'b0, `MRE_OFF_STATE, 0); `CHK("illegal state", 32'h2, rd)
        apb(1'b0, `MRE_OFF_PC, 0); `CHK("illegal pc", 32'h1, rd)
        tally_and_finish();
    end
endmodule
